// [logic/sps_pkg.sv]
package sps_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    // sfr addresses, visible from every page except page control, seen on page 0x0f only
    localparam logic [7:0] ADDR_ACTIVE_PAGE = 8'ha7;
    localparam logic [7:0] ADDR_SECOND_ENTRY = 8'h85;
    localparam logic [7:0] ADDR_THIRD_ENTRY = 8'h86;
    localparam logic [7:0] ADDR_PAGE_CONTROL = 8'h8e;
    localparam logic [7:0] PAGE_CONTROL_PAGE = 8'h0f;
    localparam int AUTO_EN_BIT = 0;
    localparam logic [7:0] RST_ACTIVE_PAGE = 8'h00;
    localparam logic [7:0] RST_SECOND_ENTRY = 8'h00;
    localparam logic [7:0] RST_THIRD_ENTRY = 8'h00;
    localparam logic RST_AUTO_EN = 1'b1;
    localparam int STACK_DEPTH = 3;
endpackage

// [logic/sps_page_stack.sv]
// Function
// - the active page register drives the page number used for every paged sfr access.
// - software writes load the active page and reads return the page in use.
// - the active page register is 8 bits, resets to zero and sits at 0xa7 on every page.
// - with automatic paging on, interrupt entry switches to the page of the requesting peripheral.
// - interrupt return restores the page in use before the interrupt, for nesting up to two deep, unless software changed the stack.
// - only interrupt entry and return push or pop; register reads and writes never do.
// - interrupt return copies the second entry into the active page register.
// - software writes replace the second entry and reads return it.
// - the second entry register is 8 bits, resets to zero and sits at 0x85 on every page.
// - the stack holds three bytes: active page, second entry, third entry.
// - software writes to stack entries change saved context without push or pop.
// - interrupt entry moves active page to second entry and second entry to third entry.
// - interrupt return moves third entry to second entry; the third entry refills with zero.
// - automatic paging comes out of reset enabled and when cleared nothing is saved or restored.
module sps_page_stack (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic INT_ENTRY_I,
    input wire logic [7:0] INT_PAGE_I,
    input wire logic INT_RETURN_I,
    output logic [7:0] SFR_RDATA_O,
    output logic SFR_HIT_O,
    output logic [7:0] ACTIVE_PAGE_O,
    output logic AUTO_EN_O
);
    typedef enum logic [1:0] {
        SPS_HOLD,
        SPS_PUSH,
        SPS_POP
    } sps_stack_op_t;

    sps_stack_op_t stack_op;
    logic [7:0] active_page_select_q;
    logic [7:0] active_page_select_d;
    logic [7:0] page_stack_second_entry_q;
    logic [7:0] page_stack_second_entry_d;
    logic [7:0] page_stack_third_entry_q;
    logic [7:0] page_stack_third_entry_d;

    logic auto_paging_enable_q;
    logic auto_paging_enable_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic hit_d;

    logic wr_active;
    logic wr_second;
    logic wr_third;
    logic wr_control;

    logic rd_active;
    logic rd_second;
    logic rd_third;
    logic rd_control;
    logic [7:0] control_readback;

    function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] target);
        is_reg = (addr == target);
    endfunction

    // the control register is paged like any peripheral register
    function automatic logic ctrl_visible(input logic [7:0] addr, input logic [7:0] page);
        ctrl_visible = is_reg(addr, sps_pkg::ADDR_PAGE_CONTROL) && (page == sps_pkg::PAGE_CONTROL_PAGE);
    endfunction

    // entry and return in one cycle: entry wins, the core returns later
    always_comb begin
        stack_op = SPS_HOLD;
        if (auto_paging_enable_q) begin
            if (INT_ENTRY_I) begin
                stack_op = SPS_PUSH;
            end else if (INT_RETURN_I) begin
                stack_op = SPS_POP;
            end
        end
    end

    assign wr_active = SFR_WR_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_ACTIVE_PAGE);
    assign wr_second = SFR_WR_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_SECOND_ENTRY);
    assign wr_third = SFR_WR_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_THIRD_ENTRY);
    assign wr_control = SFR_WR_I && ctrl_visible(SFR_ADDR_I, active_page_select_q);
    assign rd_active = SFR_RD_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_ACTIVE_PAGE);
    assign rd_second = SFR_RD_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_SECOND_ENTRY);
    assign rd_third = SFR_RD_I && is_reg(SFR_ADDR_I, sps_pkg::ADDR_THIRD_ENTRY);
    assign rd_control = SFR_RD_I && ctrl_visible(SFR_ADDR_I, active_page_select_q);
    assign control_readback = {7'h00, auto_paging_enable_q};

    // hardware moves own the whole stack in their cycle, a software write is lost
    always_comb begin
        active_page_select_d = active_page_select_q;
        unique case (stack_op)
            SPS_PUSH: begin
                active_page_select_d = INT_PAGE_I;
            end
            SPS_POP: begin
                active_page_select_d = page_stack_second_entry_q;
            end
            SPS_HOLD: begin
                if (wr_active) begin
                    active_page_select_d = SFR_WDATA_I;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            active_page_select_q <= sps_pkg::RST_ACTIVE_PAGE;
        end else begin
            active_page_select_q <= active_page_select_d;
        end
    end

    always_comb begin
        page_stack_second_entry_d = page_stack_second_entry_q;
        unique case (stack_op)
            SPS_PUSH: begin
                page_stack_second_entry_d = active_page_select_q;
            end
            SPS_POP: begin
                page_stack_second_entry_d = page_stack_third_entry_q;
            end
            SPS_HOLD: begin
                if (wr_second) begin
                    page_stack_second_entry_d = SFR_WDATA_I;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            page_stack_second_entry_q <= sps_pkg::RST_SECOND_ENTRY;
        end else begin
            page_stack_second_entry_q <= page_stack_second_entry_d;
        end
    end

    always_comb begin
        page_stack_third_entry_d = page_stack_third_entry_q;
        unique case (stack_op)
            SPS_PUSH: begin
                page_stack_third_entry_d = page_stack_second_entry_q;
            end
            SPS_POP: begin
                page_stack_third_entry_d = sps_pkg::RST_THIRD_ENTRY;
            end
            SPS_HOLD: begin
                if (wr_third) begin
                    page_stack_third_entry_d = SFR_WDATA_I;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            page_stack_third_entry_q <= sps_pkg::RST_THIRD_ENTRY;
        end else begin
            page_stack_third_entry_q <= page_stack_third_entry_d;
        end
    end

    always_comb begin
        auto_paging_enable_d = auto_paging_enable_q;
        if (wr_control) begin
            auto_paging_enable_d = SFR_WDATA_I[sps_pkg::AUTO_EN_BIT];
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            auto_paging_enable_q <= sps_pkg::RST_AUTO_EN;
        end else begin
            auto_paging_enable_q <= auto_paging_enable_d;
        end
    end

    // unmapped or hidden addresses read as zero with no hit
    always_comb begin
        rdata_d = 8'h00;
        hit_d = 1'h0;
        if (rd_active) begin
            rdata_d = active_page_select_q;
            hit_d = 1'h1;
        end else if (rd_second) begin
            rdata_d = page_stack_second_entry_q;
            hit_d = 1'h1;
        end else if (rd_third) begin
            rdata_d = page_stack_third_entry_q;
            hit_d = 1'h1;
        end else if (rd_control) begin
            rdata_d = control_readback;
            hit_d = 1'h1;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            rdata_q <= 8'h00;
            hit_q <= 1'h0;
        end else begin
            rdata_q <= rdata_d;
            hit_q <= hit_d;
        end
    end

    assign SFR_RDATA_O = rdata_q;
    assign SFR_HIT_O = hit_q;
    assign ACTIVE_PAGE_O = active_page_select_q;
    assign AUTO_EN_O = auto_paging_enable_q;
endmodule

// [testbench/sps_page_stack_chk.sv]
module sps_chk (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic SFR_WR_I,
    input wire logic SFR_RD_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic INT_ENTRY_I,
    input wire logic [7:0] INT_PAGE_I,
    input wire logic INT_RETURN_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic SFR_HIT_O,
    input wire logic [7:0] ACTIVE_PAGE_O,
    input wire logic AUTO_EN_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    wire logic hw = INT_ENTRY_I || INT_RETURN_I;
    property p_hold; !SFR_WR_I && (!hw || !AUTO_EN_O) |=> $stable(ACTIVE_PAGE_O); endproperty
    a_hold: assert property (p_hold) else $error("page moved");
    property p_pop; INT_ENTRY_I && AUTO_EN_O && !SFR_WR_I ##1 !SFR_WR_I && !hw
        ##1 INT_RETURN_I && !INT_ENTRY_I && !SFR_WR_I |=> ACTIVE_PAGE_O == $past(ACTIVE_PAGE_O, 3); endproperty
    a_pop: assert property (p_pop) else $error("no restore");
    property p_push; INT_ENTRY_I && AUTO_EN_O |=> ACTIVE_PAGE_O == $past(INT_PAGE_I); endproperty
    a_push: assert property (p_push) else $error("entry page not taken");
    property p_write; SFR_WR_I && SFR_ADDR_I == sps_pkg::ADDR_ACTIVE_PAGE && !(hw && AUTO_EN_O)
        |=> ACTIVE_PAGE_O == $past(SFR_WDATA_I); endproperty
    a_write: assert property (p_write) else $error("page write lost");
    property p_read; SFR_RD_I && SFR_ADDR_I == sps_pkg::ADDR_ACTIVE_PAGE
        |=> SFR_HIT_O && SFR_RDATA_O == $past(ACTIVE_PAGE_O); endproperty
    a_read: assert property (p_read) else $error("page read wrong");
    property p_idle; !SFR_RD_I |=> !SFR_HIT_O && SFR_RDATA_O == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without read");
    property p_next; INT_ENTRY_I && AUTO_EN_O ##1 SFR_RD_I && SFR_ADDR_I == sps_pkg::ADDR_SECOND_ENTRY
        |=> SFR_RDATA_O == $past(ACTIVE_PAGE_O, 2); endproperty
    a_next: assert property (p_next) else $error("page not saved");
    property p_hit; SFR_RD_I && SFR_ADDR_I == sps_pkg::ADDR_SECOND_ENTRY |=> SFR_HIT_O; endproperty
    a_hit: assert property (p_hit) else $error("second entry not reached");
endmodule
bind sps_page_stack sps_chk sps_chk_inst(
    .CLK_I(CLK_I),
    .RESET_I(RESET_I),
    .SFR_WR_I(SFR_WR_I),
    .SFR_RD_I(SFR_RD_I),
    .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WDATA_I(SFR_WDATA_I),
    .INT_ENTRY_I(INT_ENTRY_I),
    .INT_PAGE_I(INT_PAGE_I),
    .INT_RETURN_I(INT_RETURN_I),
    .SFR_RDATA_O(SFR_RDATA_O),
    .SFR_HIT_O(SFR_HIT_O),
    .ACTIVE_PAGE_O(ACTIVE_PAGE_O),
    .AUTO_EN_O(AUTO_EN_O)
);

// [testbench/sps_core_model.sv]
module sps_core_model (
    input wire logic clk_i,
    output logic ent_o,
    output logic ret_o,
    output logic [7:0] page_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ent_o = 1'h0;
        ret_o = 1'h0;
        page_o = 8'h00;
    end
    // one-cycle event pulse; the page bus shows garbage once released
    task automatic fire(input logic e, input logic r, input logic [7:0] p);
        @(posedge clk_i);
        ent_o <= e;
        ret_o <= r;
        page_o <= p;
        @(posedge clk_i);
        ent_o <= 1'h0;
        ret_o <= 1'h0;
        page_o <= ~p;
        #1;
    endtask
endmodule

// [testbench/tb_sps_page_stack.sv]
`define CK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("unexpected %0t: value mismatch", $time); end end
module tb_sps_page_stack;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK_I = 1'h0;
    logic RESET_I = 1'h1;
    logic SFR_WR_I = 1'h0;
    logic SFR_RD_I = 1'h0;
    logic [7:0] SFR_ADDR_I = 8'h00;
    logic [7:0] SFR_WDATA_I = 8'h00;
    logic INT_ENTRY_I;
    logic INT_RETURN_I;
    logic [7:0] INT_PAGE_I;
    logic [7:0] SFR_RDATA_O;
    logic SFR_HIT_O;
    logic [7:0] ACTIVE_PAGE_O;
    logic AUTO_EN_O;
    int errors = 0;
    int num_checks = 0;
    always #25 CLK_I = ~CLK_I;
    sps_core_model sps_core_model_inst(.clk_i(CLK_I), .ent_o(INT_ENTRY_I), .ret_o(INT_RETURN_I), .page_o(INT_PAGE_I));
    sps_page_stack sps_page_stack_inst(
        .CLK_I(CLK_I),
        .RESET_I(RESET_I),
        .SFR_WR_I(SFR_WR_I),
        .SFR_RD_I(SFR_RD_I),
        .SFR_ADDR_I(SFR_ADDR_I),
        .SFR_WDATA_I(SFR_WDATA_I),
        .INT_ENTRY_I(INT_ENTRY_I),
        .INT_PAGE_I(INT_PAGE_I),
        .INT_RETURN_I(INT_RETURN_I),
        .SFR_RDATA_O(SFR_RDATA_O),
        .SFR_HIT_O(SFR_HIT_O),
        .ACTIVE_PAGE_O(ACTIVE_PAGE_O),
        .AUTO_EN_O(AUTO_EN_O)
    );
    // h is the expected hit; read data is judged in the cycle it stands
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic h);
        @(posedge CLK_I);
        SFR_WR_I <= w;
        SFR_RD_I <= !w;
        SFR_ADDR_I <= a;
        SFR_WDATA_I <= d;
        @(posedge CLK_I);
        SFR_WR_I <= 1'h0;
        SFR_RD_I <= 1'h0;
        #1;
        if (!w) begin
            `CK({SFR_HIT_O, SFR_RDATA_O}, {h, d})
        end
    endtask
    task automatic ev(input logic n, input logic [7:0] p, input logic [7:0] x);
        sps_core_model_inst.fire(n, !n, p);
        `CK(ACTIVE_PAGE_O, x)
    endtask
    task automatic t_regs;
        `CK({ACTIVE_PAGE_O, AUTO_EN_O, SFR_HIT_O}, 10'h002)
        acc(1'h1, 8'ha7, 8'h02, 1'h1);
        acc(1'h1, 8'h85, 8'h05, 1'h1);
        acc(1'h0, 8'ha7, 8'h02, 1'h1);
        acc(1'h0, 8'h85, 8'h05, 1'h1);
        `CK(ACTIVE_PAGE_O, 8'h02)
        acc(1'h0, 8'h8e, 8'h00, 1'h0);
        acc(1'h0, 8'h90, 8'h00, 1'h0);
    endtask
    task automatic t_stack;
        ev(1'h1, 8'h0f, 8'h0f);
        ev(1'h0, 8'h00, 8'h02);
        acc(1'h0, 8'h86, 8'h00, 1'h1);
        ev(1'h1, 8'h03, 8'h03);
        acc(1'h0, 8'h86, 8'h05, 1'h1);
        acc(1'h1, 8'h85, 8'h07, 1'h1);
        `CK(ACTIVE_PAGE_O, 8'h03)
        ev(1'h0, 8'h00, 8'h07);
    endtask
    task automatic t_prio;
        fork
            sps_core_model_inst.fire(1'h1, 1'h0, 8'h02);
            acc(1'h1, 8'h85, 8'h09, 1'h0);
        join
        `CK(ACTIVE_PAGE_O, 8'h02)
        acc(1'h0, 8'h85, 8'h07, 1'h1);
        acc(1'h0, 8'h86, 8'h05, 1'h1);
        sps_core_model_inst.fire(1'h1, 1'h1, 8'h0f);
        `CK(ACTIVE_PAGE_O, 8'h0f)
        acc(1'h0, 8'h86, 8'h07, 1'h1);
        fork
            sps_core_model_inst.fire(1'h1, 1'h0, 8'h03);
            begin
                @(posedge CLK_I);
                acc(1'h0, 8'h85, 8'h0f, 1'h1);
            end
        join
        ev(1'h0, 8'h00, 8'h0f);
        ev(1'h0, 8'h00, 8'h02);
        ev(1'h0, 8'h00, 8'h00);
    endtask
    task automatic t_auto;
        acc(1'h1, 8'ha7, 8'h0f, 1'h1);
        acc(1'h0, 8'h8e, 8'h01, 1'h1);
        acc(1'h1, 8'h8e, 8'h00, 1'h1);
        `CK(AUTO_EN_O, 1'h0)
        ev(1'h1, 8'h03, 8'h0f);
        ev(1'h0, 8'h00, 8'h0f);
        acc(1'h0, 8'h85, 8'h00, 1'h1);
    endtask
    task automatic t_reset;
        @(posedge CLK_I);
        RESET_I <= 1'h1;
        repeat (2) @(posedge CLK_I);
        RESET_I <= 1'h0;
        #1;
        `CK({ACTIVE_PAGE_O, AUTO_EN_O, SFR_HIT_O}, 10'h002)
        ev(1'h1, 8'h05, 8'h05);
        acc(1'h0, 8'h85, 8'h00, 1'h1);
    endtask
    task conclude;
        if (errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge CLK_I);
        RESET_I <= 1'h0;
        #1;
        t_regs();
        t_stack();
        t_prio();
        t_auto();
        t_reset();
        conclude();
    end
    // over five times the length of the scenarios
    initial begin
        #20000;
        errors++;
        conclude();
    end
endmodule
